// file: debug_and_test_port.v
// What this block does
// (RULE_01) interface-select level held through reset picks JTAG or serial debug mode
// (RULE_02) low test reset returns JTAG logic to its initial state at once
// (RULE_03) TMS and TDI are sampled at each test clock rising edge
// (RULE_04) TDO driven only in Shift-IR and Shift-DR, changes at falling edge
// (RULE_05) serial clock level valid after two equal consecutive bus clock samples
// (RULE_06) debugger keeps serial clock below one fifth of status clock; serial_debugger runs it at exactly one fifth (100 ns vs 20 ns)
// (RULE_07) each validated serial clock rise samples input and changes output
// (RULE_08) serial input is taken once serial clock is seen high
// (RULE_09) serial output is registered, changing after serial clock high validation
// (RULE_10) breakpoint request halts after current instruction; status then shows 0xF
// (RULE_11) with breakpoint disable set, breakpoint request raises debug interrupt instead
// (RULE_12) status clock rises mid-way through each valid status and data output
// (RULE_13) status clock disable freezes trace outputs; triggers keep working
// (RULE_14) status clock starts only after first status of 0xC, 0xD or 0xF
// (RULE_15) status outputs follow core state on processor clock, not bus transfers
// (RULE_16) debug data outputs present captured processor data
// (RULE_17) all-status output is AND of the four status outputs
// (RULE_18) JTAG controller uses the sixteen-state test access port sequence
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "debug_port_map.vh"
module debug_and_test_port #(
  // arbitrary value, not a real device code
  parameter [31:0] ID_CODE = 32'h0000_1001
) (
  input wire mclk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire jtagEnablePin,
  input wire trstN,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdoEn,
  input wire devSerialClock,
  input wire devSerialIn,
  output reg devSerialOut,
  input wire breakpointRequest,
  input wire coreInstrDone,
  input wire [3:0] coreStatus,
  input wire [3:0] coreDebugData,
  output reg haltRequest,
  output reg debugInterrupt,
  output reg [3:0] processorStatus,
  output reg [3:0] debugDataOut,
  output reg statusClock,
  output reg allStatusAnd
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [2:0] tckS_r;
  reg [1:0] tmsS_r;
  reg [1:0] tdiS_r;
  reg [2:0] dsclkS_r;
  reg [1:0] dsiS_r;
  reg [2:0] bkptS_r;
  reg [1:0] jtagEnS_r;

  always @(posedge mclk) begin
    if (sys_rst) begin
      tckS_r <= 3'h0;
      tmsS_r <= 2'h3;
      tdiS_r <= 2'h3;
      dsclkS_r <= 3'h0;
      dsiS_r <= 2'h0;
      bkptS_r <= 3'h0;
      // keeps sampling in reset: the mode is taken from the pin while reset is held
      jtagEnS_r <= {jtagEnS_r[0], jtagEnablePin};
    end else begin
      tckS_r <= {tckS_r[1:0], tck};
      tmsS_r <= {tmsS_r[0], tms};
      tdiS_r <= {tdiS_r[0], tdi};
      dsclkS_r <= {dsclkS_r[1:0], devSerialClock};
      dsiS_r <= {dsiS_r[0], devSerialIn};
      bkptS_r <= {bkptS_r[1:0], breakpointRequest};
      jtagEnS_r <= {jtagEnS_r[0], jtagEnablePin};
    end
  end

  // mode is latched all through reset, frozen at release
  reg modeJtag_r;
  always @(posedge mclk) begin
    if (sys_rst) begin
      modeJtag_r <= jtagEnS_r[1]; // RULE_01
    end
  end

  wire tckRise = modeJtag_r & tckS_r[1] & ~tckS_r[2];
  wire tckFall = modeJtag_r & ~tckS_r[1] & tckS_r[2];
  wire bkptRise = bkptS_r[1] & ~bkptS_r[2];

  // ----------------------------------------
  // test access port
  // ----------------------------------------
  wire [3:0] tapState;
  reg [3:0] irShift_r;
  reg [3:0] ir_r;
  reg [31:0] drShift_r;
  wire irBypass = (ir_r != `IR_IDCODE);

  tap_controller tapCtl (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .trstN(trstN),
    .tckRise(tckRise),
    .tms(tmsS_r[1]),
    .tapState_r(tapState)
  );

  always @(posedge mclk or negedge trstN) begin
    if (!trstN) begin
      irShift_r <= `IR_CAPTURE; // RULE_02
      ir_r <= `IR_IDCODE;
      drShift_r <= 32'h0000_0000;
      tdo <= 1'b0;
      tdoEn <= 1'b0;
    end else if (sys_rst) begin
      irShift_r <= `IR_CAPTURE;
      ir_r <= `IR_IDCODE;
      drShift_r <= 32'h0000_0000;
      tdo <= 1'b0;
      tdoEn <= 1'b0;
    end else begin
      if (tckRise) begin
        case (tapState) // RULE_03
          `TAP_RESET: ir_r <= `IR_IDCODE;
          `TAP_CAP_IR: irShift_r <= `IR_CAPTURE;
          `TAP_SHIFT_IR: irShift_r <= {tdiS_r[1], irShift_r[3:1]};
          `TAP_UPD_IR: ir_r <= irShift_r;
          `TAP_CAP_DR: drShift_r <= irBypass ? 32'h0000_0000 : ID_CODE;
          `TAP_SHIFT_DR: begin
            if (irBypass) begin
              drShift_r <= {31'h0000_0000, tdiS_r[1]};
            end else begin
              drShift_r <= {tdiS_r[1], drShift_r[31:1]};
            end
          end
          default: ir_r <= ir_r;
        endcase
      end
      if (tckFall) begin
        // RULE_04
        tdoEn <= (tapState == `TAP_SHIFT_IR) | (tapState == `TAP_SHIFT_DR);
        tdo <= (tapState == `TAP_SHIFT_IR) ? irShift_r[0] : drShift_r[0];
      end
    end
  end

  // ----------------------------------------
  // serial debug link
  // ----------------------------------------
  reg dsclkLvl_r;
  reg [3:0] serBit_r;
  reg [15:0] rxShift_r;
  reg [15:0] rxWord_r;
  reg [15:0] txShift_r;
  reg [15:0] txData_r;
  reg rxValid_r;
  reg rxClear;
  // level only counts once two samples agree; glitches shorter than a cycle vanish
  wire dsclkAgree = (dsclkS_r[1] == dsclkS_r[2]); // RULE_05
  wire dsRise = ~modeJtag_r & dsclkAgree & dsclkS_r[1] & ~dsclkLvl_r; // RULE_07
  wire [15:0] rxNext = {rxShift_r[14:0], dsiS_r[1]}; // RULE_08

  always @(posedge mclk) begin
    if (sys_rst) begin
      dsclkLvl_r <= 1'b0;
      serBit_r <= 4'h0;
      rxShift_r <= 16'h0000;
      rxWord_r <= 16'h0000;
      txShift_r <= `TX_RESET;
      rxValid_r <= 1'b0;
      devSerialOut <= 1'b0;
    end else begin
      if (dsclkAgree) begin
        dsclkLvl_r <= dsclkS_r[1];
      end
      if (rxClear) begin
        rxValid_r <= 1'b0;
      end
      if (dsRise) begin
        rxShift_r <= rxNext;
        serBit_r <= serBit_r + 4'h1;
        // output leaves one cycle after the high level is validated
        if (serBit_r == 4'h0) begin
          devSerialOut <= txData_r[15]; // RULE_09
          txShift_r <= {txData_r[14:0], 1'b0};
        end else begin
          devSerialOut <= txShift_r[15]; // RULE_09
          txShift_r <= {txShift_r[14:0], 1'b0};
        end
        if (serBit_r == `SER_LAST_BIT) begin
          rxWord_r <= rxNext;
          rxValid_r <= 1'b1; // set wins over a clear in the same cycle
        end
      end
    end
  end

  // ----------------------------------------
  // breakpoint and halt
  // ----------------------------------------
  reg cfgBkd_r;
  reg cfgPcd_r;
  reg halted_r;
  reg resume;

  always @(posedge mclk) begin
    if (sys_rst) begin
      haltRequest <= 1'b0;
      halted_r <= 1'b0;
      debugInterrupt <= 1'b0;
    end else begin
      debugInterrupt <= bkptRise & cfgBkd_r; // RULE_11
      if (resume) begin
        halted_r <= 1'b0;
      end
      if (bkptRise & ~cfgBkd_r & ~halted_r) begin
        haltRequest <= 1'b1; // RULE_10
      end else if (haltRequest & coreInstrDone) begin
        haltRequest <= 1'b0;
        halted_r <= 1'b1; // RULE_10
      end
    end
  end

  // ----------------------------------------
  // real-time trace outputs
  // ----------------------------------------
  reg divPhase_r;
  reg started_r;
  wire [3:0] pstNext = halted_r ? `PST_HALTED : coreStatus; // RULE_10
  wire pstFirst = (pstNext == `PST_START_C) | (pstNext == `PST_START_D) |
                  (pstNext == `PST_HALTED);

  always @(posedge mclk) begin
    if (sys_rst) begin
      divPhase_r <= 1'b0;
      started_r <= 1'b0;
      processorStatus <= 4'h0;
      debugDataOut <= 4'h0;
      allStatusAnd <= 1'b0;
      statusClock <= 1'b0;
    end else begin
      divPhase_r <= ~divPhase_r;
      if (pstFirst) begin
        started_r <= 1'b1; // RULE_14
      end
      // disable freezes trace only; breakpoints above still act
      if (!cfgPcd_r) begin // RULE_13
        if (!divPhase_r) begin
          processorStatus <= pstNext; // RULE_15
          debugDataOut <= coreDebugData; // RULE_16
          allStatusAnd <= &pstNext; // RULE_17
          statusClock <= 1'b0;
        end else if (started_r) begin
          statusClock <= 1'b1; // RULE_12
        end
      end
    end
  end

  // ----------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------
  reg wrPend_r;
  reg [7:0] wrAddr_r;
  reg [31:0] rdMux;
  wire [1:0] cfgReset = `CFG_RESET;
  wire addrTaken = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];

  always @* begin
    rdMux = 32'h0000_0000;
    case (haddr[7:0])
      `REG_CONFIG: rdMux = {30'h0000_0000, cfgPcd_r, cfgBkd_r};
      `REG_STATUS: rdMux = {27'h0000_0000, haltRequest, started_r, rxValid_r,
                            modeJtag_r, halted_r};
      `REG_RXDATA: rdMux = {16'h0000, rxWord_r};
      `REG_TXDATA: rdMux = {16'h0000, txData_r};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always @* begin
    resume = wrPend_r & (wrAddr_r == `REG_CONFIG) & hwdata[`CFG_RESUME_BIT];
    rxClear = wrPend_r & (wrAddr_r == `REG_STATUS) & hwdata[`STS_RXVALID_BIT];
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cfgBkd_r <= cfgReset[`CFG_BKD_BIT];
      cfgPcd_r <= cfgReset[`CFG_PCD_BIT];
      txData_r <= `TX_RESET;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_r <= addrTaken & hwrite;
      if (addrTaken) begin
        wrAddr_r <= haddr[7:0];
        hrdata <= hwrite ? 32'h0000_0000 : rdMux;
      end
      if (wrPend_r & (wrAddr_r == `REG_CONFIG)) begin
        cfgBkd_r <= hwdata[`CFG_BKD_BIT];
        cfgPcd_r <= hwdata[`CFG_PCD_BIT];
      end
      if (wrPend_r & (wrAddr_r == `REG_TXDATA)) begin
        txData_r <= hwdata[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: debug_and_test_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module debug_and_test_port_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic trstN,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdoEn,
  input wire logic devSerialClock,
  input wire logic devSerialOut,
  input wire logic breakpointRequest,
  input wire logic coreInstrDone,
  input wire logic [3:0] coreStatus,
  input wire logic haltRequest,
  input wire logic debugInterrupt,
  input wire logic [3:0] processorStatus,
  input wire logic [3:0] debugDataOut,
  input wire logic statusClock,
  input wire logic allStatusAnd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic seenStart_r;
  // ----------------------------------------
  // start code seen on the core side
  // ----------------------------------------
  always @(posedge mclk) begin
    if (sys_rst)
      seenStart_r <= 1'b0;
    else if (coreStatus == 4'hC || coreStatus == 4'hD || coreStatus == 4'hF)
      seenStart_r <= 1'b1;
  end
  property p_andAll;
    allStatusAnd == &processorStatus;
  endproperty
  a_andAll: assert property (p_andAll)
    else $error("all-status output differs from and of status");
  property p_tdoFall;
    trstN && $past(trstN) && ($changed(tdo) || $changed(tdoEn)) |-> !tck;
  endproperty
  a_tdoFall: assert property (p_tdoFall)
    else $error("test data output moved while test clock high");
  property p_trst;
    !trstN |=> !tdoEn && !tdo;
  endproperty
  a_trst: assert property (p_trst)
    else $error("test reset did not release test data output");
  property p_traceMid;
    $changed(processorStatus) || $changed(debugDataOut) |-> !statusClock;
  endproperty
  a_traceMid: assert property (p_traceMid)
    else $error("trace data changed with status clock high");
  property p_start;
    $rose(statusClock) |-> seenStart_r;
  endproperty
  a_start: assert property (p_start)
    else $error("status clock started before a start code");
  property p_halt;
    haltRequest && coreInstrDone |=> !haltRequest ##[0:3] processorStatus == 4'hF;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt not shown on status outputs");
  property p_dbgInt;
    debugInterrupt |-> $past(breakpointRequest) && !haltRequest ##1 !debugInterrupt;
  endproperty
  a_dbgInt: assert property (p_dbgInt)
    else $error("debug interrupt without breakpoint or too long");
  property p_serOut;
    $changed(devSerialOut) |-> $past(devSerialClock, 2) && $past(devSerialClock, 3);
  endproperty
  a_serOut: assert property (p_serOut)
    else $error("serial output moved without a validated clock rise");
endmodule
bind debug_and_test_port debug_and_test_port_monitor i_debug_and_test_port_monitor (
  .mclk, .sys_rst, .trstN, .tck, .tdo, .tdoEn, .devSerialClock, .devSerialOut,
  .breakpointRequest, .coreInstrDone, .coreStatus, .haltRequest, .debugInterrupt,
  .processorStatus, .debugDataOut, .statusClock, .allStatusAnd
);
`default_nettype wire

// file: debug_port_map.vh
`ifndef DEBUG_PORT_MAP_VH
`define DEBUG_PORT_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_RXDATA 8'h08
`define REG_TXDATA 8'h0C
// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_BKD_BIT 0
`define CFG_PCD_BIT 1
`define CFG_RESUME_BIT 2
`define STS_HALTED_BIT 0
`define STS_JTAG_BIT 1
`define STS_RXVALID_BIT 2
`define STS_STARTED_BIT 3
`define STS_HALTREQ_BIT 4
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define CFG_RESET 2'h0
`define TX_RESET 16'h0000
`define PST_HALTED 4'hF
`define PST_START_C 4'hC
`define PST_START_D 4'hD
`define IR_BYPASS 4'hF
`define IR_IDCODE 4'h1
`define IR_CAPTURE 4'h1
`define SER_LAST_BIT 4'hF
`define HTRANS_NONSEQ_BIT 1
// ----------------------------------------
// test access port states
// ----------------------------------------
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1_DR 4'h5
`define TAP_PAUSE_DR 4'h6
`define TAP_EXIT2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'hA
`define TAP_SHIFT_IR 4'hB
`define TAP_EXIT1_IR 4'hC
`define TAP_PAUSE_IR 4'hD
`define TAP_EXIT2_IR 4'hE
`define TAP_UPD_IR 4'hF
`endif

// file: serial_debugger.sv
`timescale 1ns/1ns
`default_nettype none
module serial_debugger (
  output var logic devSerialClock,
  output var logic devSerialIn,
  input wire logic devSerialOut
);
  initial begin
    devSerialClock = 1'b0;
    devSerialIn = 1'b0;
  end
  // ----------------------------------------
  // one packet, msb first both ways
  // ----------------------------------------
  // 100 ns period keeps the link at a fifth of the 50 MHz status clock
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    for (int k = 15; k >= 0; k--) begin
      devSerialIn = tx[k];
      #20 devSerialClock = 1'b1;
      #50 devSerialClock = 1'b0;
      #30 rx[k] = devSerialOut;
    end
    // undriven data line must not look like the last bit
    devSerialIn = ~devSerialIn;
  endtask
  // spike seen high at one bus clock edge only; must not advance the bit count
  task automatic glitch;
    #2 devSerialClock = 1'b1;
    #10 devSerialClock = 1'b0;
    #28;
  endtask
endmodule
`default_nettype wire

// file: tap_controller.v
`timescale 1ns/1ns
`default_nettype none
`include "debug_port_map.vh"
module tap_controller (
  input wire mclk,
  input wire sys_rst,
  input wire trstN,
  input wire tckRise,
  input wire tms,
  output reg [3:0] tapState_r
);
  reg [3:0] tapState_nxt;

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // trstN acts without any clock edge
  always @(posedge mclk or negedge trstN) begin
    if (!trstN) begin
      tapState_r <= `TAP_RESET; // RULE_02
    end else if (sys_rst) begin
      tapState_r <= `TAP_RESET;
    end else if (tckRise) begin
      tapState_r <= tapState_nxt; // RULE_03
    end
  end

  // ----------------------------------------
  // sixteen-state sequence
  // ----------------------------------------
  always @* begin
    tapState_nxt = tapState_r;
    case (tapState_r) // RULE_18
      `TAP_RESET: tapState_nxt = tms ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE: tapState_nxt = tms ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_DR: tapState_nxt = tms ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR: tapState_nxt = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: tapState_nxt = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_EXIT1_DR: tapState_nxt = tms ? `TAP_UPD_DR : `TAP_PAUSE_DR;
      `TAP_PAUSE_DR: tapState_nxt = tms ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
      `TAP_EXIT2_DR: tapState_nxt = tms ? `TAP_UPD_DR : `TAP_SHIFT_DR;
      `TAP_UPD_DR: tapState_nxt = tms ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_IR: tapState_nxt = tms ? `TAP_RESET : `TAP_CAP_IR;
      `TAP_CAP_IR: tapState_nxt = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_SHIFT_IR: tapState_nxt = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_EXIT1_IR: tapState_nxt = tms ? `TAP_UPD_IR : `TAP_PAUSE_IR;
      `TAP_PAUSE_IR: tapState_nxt = tms ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
      `TAP_EXIT2_IR: tapState_nxt = tms ? `TAP_UPD_IR : `TAP_SHIFT_IR;
      `TAP_UPD_IR: tapState_nxt = tms ? `TAP_SEL_DR : `TAP_IDLE;
      default: tapState_nxt = `TAP_RESET;
    endcase
  end
endmodule
`default_nettype wire

// file: tb_debug_and_test_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_debug_and_test_port;
  logic mclk, sys_rst, hsel, hwrite, jtagEnablePin, trstN, tck, tms, tdi, hit;
  logic breakpointRequest, coreInstrDone, hreadyout, hresp, tdo, tdoEn;
  logic devSerialClock, devSerialIn, devSerialOut, haltRequest, debugInterrupt;
  logic statusClock, allStatusAnd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] coreStatus, coreDebugData, processorStatus, debugDataOut, ps, dd;
  logic [15:0] tx, rxw, got;
  int mismatches, tests_run, seed;
  debug_and_test_port i_debug_and_test_port (.*, .hready(hreadyout));
  serial_debugger i_serial_debugger (.devSerialClock, .devSerialIn, .devSerialOut);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // bus and pin tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
    // read data come from the address phase, so let a write just before it land first
    @(posedge mclk);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("response", 32'h0, hresp);
  endtask
  task automatic rst(input logic j);
    jtagEnablePin <= j;
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic tstep(input logic m);
    tms <= m;
    tdi <= 1'($urandom);
    repeat (4) @(posedge mclk);
    tck <= 1'b1;
    repeat (4) @(posedge mclk);
    tck <= 1'b0;
  endtask
  task automatic walk;
    for (int i = 0; i < 5; i++) tstep(i == 1 || i == 2);
    repeat (5) @(posedge mclk);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = $urandom(32'hCB53);
    {hsel, hwrite, tck, tms, tdi, breakpointRequest, coreInstrDone} = '0;
    {haddr, hwdata, htrans, coreStatus, coreDebugData, jtagEnablePin} = '0;
    hsize = 3'h2;
    trstN = 1'b1;
    sys_rst = 1'b1;
    @(posedge mclk);
    hsel <= 1'b1;
    rst(1'b0);
    rdChk("status", 8'h04, 32'h0);
    rdChk("unmapped", 8'h10, 32'h0);
    ahb(1'b1, 8'h00, 32'h7);
    rdChk("config", 8'h00, 32'h3);
    ahb(1'b1, 8'h00, 32'h0);
    repeat (20) begin
      coreStatus <= 4'($urandom % 12);
      @(posedge mclk);
      chk("idle clock", 32'h0, statusClock);
    end
    for (int i = 0; i < 24; i++) begin
      ps = (i == 0) ? 4'hC : (i == 1) ? 4'hF : 4'($urandom);
      dd = 4'($urandom);
      coreStatus <= ps;
      coreDebugData <= dd;
      repeat (5) @(posedge mclk);
      chk("status", ps, processorStatus);
      chk("data", dd, debugDataOut);
      chk("and", &ps, allStatusAnd);
    end
    rdChk("started", 8'h04, 32'h8);
    ahb(1'b1, 8'h00, 32'h2);
    coreStatus <= ~ps;
    breakpointRequest <= 1'b1;
    repeat (8) @(posedge mclk);
    breakpointRequest <= 1'b0;
    chk("frozen", ps, processorStatus);
    rdChk("trigger", 8'h04, 32'h18);
    ahb(1'b1, 8'h00, 32'h0);
    coreInstrDone <= 1'b1;
    @(posedge mclk);
    coreInstrDone <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("halt code", 4'hF, processorStatus);
    rdChk("halted", 8'h04, 32'h9);
    ahb(1'b1, 8'h00, 32'h4);
    rdChk("resumed", 8'h04, 32'h8);
    ahb(1'b1, 8'h00, 32'h1);
    breakpointRequest <= 1'b1;
    hit = 1'b0;
    repeat (8) begin
      @(posedge mclk);
      hit |= debugInterrupt;
    end
    breakpointRequest <= 1'b0;
    chk("interrupt", 32'h1, hit);
    rdChk("no halt", 8'h04, 32'h8);
    ahb(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      tx = (i == 0) ? 16'h8001 : 16'($urandom);
      rxw = (i == 1) ? 16'hFFFF : 16'($urandom);
      ahb(1'b1, 8'h0C, {16'h0, tx});
      if (i == 2) i_serial_debugger.glitch;
      i_serial_debugger.xfer(rxw, got);
      @(posedge mclk);
      chk("serial out", tx, got);
      rdChk("serial in", 8'h08, rxw);
      rdChk("rx valid", 8'h04, 32'hC);
      ahb(1'b1, 8'h04, 32'h4);
    end
    rdChk("rx clear", 8'h04, 32'h8);
    coreStatus <= 4'h0;
    rst(1'b1);
    rdChk("jtag mode", 8'h04, 32'h2);
    walk;
    chk("shift enable", 32'h1, tdoEn);
    chk("capture bit", 32'h1, tdo);
    trstN <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("test reset", 32'h0, tdoEn);
    trstN <= 1'b1;
    walk;
    tstep(1'b1);
    repeat (5) @(posedge mclk);
    chk("exit enable", 32'h0, tdoEn);
    print_verdict;
  end
endmodule
`default_nettype wire
